// file: hw/ppmr_pkg.sv
// constants for the power management capability register set
package ppmr_pkg;
	// byte offsets in configuration space
	localparam logic [7:0] PPMR_OFS_CAP = 8'h46;
	localparam logic [7:0] PPMR_OFS_CSR = 8'h48;
	localparam logic [7:0] PPMR_OFS_EXT = 8'h4A;
	// values after global reset
	localparam logic [15:0] PPMR_CAP_RESET = 16'h7E02;
	localparam logic [15:0] PPMR_CSR_RESET = 16'h0000;
	localparam logic [15:0] PPMR_EXT_VALUE = 16'h0000;
	localparam logic [1:0] PPMR_PS_RESET = 2'h0;
	// capability fields
	localparam int PPMR_CAP_COLD_BIT = 15;
	localparam logic [3:0] PPMR_WAKE_SUPPORT = 4'hF;
	localparam logic [2:0] PPMR_AUX_SELF = 3'h0;
	localparam logic [2:0] PPMR_AUX_55MA = 3'h1;
	localparam logic [2:0] PPMR_CAP_REV = 3'h2;
	// control/status fields
	localparam int PPMR_CSR_STS_BIT = 15;
	localparam int PPMR_CSR_ENB_BIT = 8;
	localparam int PPMR_CSR_PS_LSB = 0;
	// power states
	localparam logic [1:0] PPMR_PS_D0 = 2'h0;
	localparam logic [1:0] PPMR_PS_D1 = 2'h1;
	localparam logic [1:0] PPMR_PS_D2 = 2'h2;
	localparam logic [1:0] PPMR_PS_D3 = 2'h3;
	// cycles from a configuration request to its answer
	localparam int PPMR_ACK_CYCLES = 1;
endpackage

// file: hw/ppmr_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module ppmr_sync (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// level
	input wire logic async_in,
	output logic sync_out
);
	logic meta;
	logic next_meta;
	logic next_sync;

	always_comb begin
		next_meta = async_in;
		next_sync = meta;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= next_meta;
			sync_out <= next_sync;
		end
	end
endmodule

// file: hw/ppmr_wake.sv
// wake status flag and open-drain wake pin drive
`timescale 1ns/1ps
module ppmr_wake (
	// clock and global reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// control
	input wire logic event_in,
	input wire logic clear_in,
	input wire logic enable_in,
	// state
	output logic status_out,
	output logic pin_oe_out
);
	logic next_status;
	logic next_oe;

	always_comb begin
		// an event in the clearing cycle is kept: set wins
		next_status = event_in | (status_out & ~clear_in); // RULE10 RULE11
		next_oe = next_status & enable_in; // RULE13
	end

	// only the global reset, or clear_in without event_in, clears the flag
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin // RULE17
			status_out <= 1'b0;
			pin_oe_out <= 1'b0;
		end else begin
			status_out <= next_status;
			pin_oe_out <= next_oe;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	a_event_sets: assert property (event_in |=> status_out) // RULE10
		else $error("wake event did not set status");
	a_clear_drops: assert property (
		clear_in && !event_in |=> !status_out && !pin_oe_out) // RULE11
		else $error("wake clear left status or pin active");
endmodule

// file: hw/ppmr_regs.sv
// power management capability, control/status and extension registers
//
// Function
// RULE1: wake state support field reads 1111b, wake from D3hot, D2, D1, D0.
// RULE2: capability bit 10 fixed one, deep doze state supported.
// RULE3: capability bit 9 fixed one, light doze state supported.
// RULE4: aux current reads 000b when cold wake unsupported, else 001b.
// RULE5: capability bit 5 reads zero, no special initialization needed.
// RULE6: capability bit 3 reads zero, no bus clock needed for wake.
// RULE7: capability revision bits 2 to 0 read 010b.
// RULE8: capability bit 4 reserved, reads zero.
// RULE9: control/status survives the internal reset on D3hot to D0.
// RULE10: wake status sets on every wake event, whatever wake enable holds.
// RULE11: writing one clears wake status and releases the pin; zero no effect.
// RULE12: data scale and data select fields read zero.
// RULE13: wake pin may be driven only while wake enable is one.
// RULE14: wake enable resets to zero; sticky, software clears it on load.
// RULE15: power state field: 00 D0, 01 D1, 10 D2, 11 D3.
// RULE16: control/status bits 7 to 2 reserved, read zero.
// RULE17: wake status, wake enable, power state cleared only by global reset.
// RULE18: extension register is read-only and reads zero.
// RULE19: writes to read-only or reserved fields are ignored.
`timescale 1ns/1ps
module ppmr_regs (
	// clock and global reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// configuration access, dword addressed
	input wire logic cfg_rd_in,
	input wire logic cfg_wr_in,
	input wire logic [5:0] cfg_dw_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_ack_out,
	// wake sources
	input wire logic wake_event_in,
	input wire logic wake_from_cold_capable_in,
	// device side
	output logic wake_oe_out,
	output logic [1:0] power_state_sel_out,
	output logic func_reset_out
);
	import ppmr_pkg::*;

	function automatic logic dword_hit(logic [5:0] dw, logic [7:0] ofs);
		return dw == ofs[7:2];
	endfunction

	// a 16-bit register sits in the low or high half of its dword
	function automatic logic [31:0] place16(logic [7:0] ofs,
		logic [15:0] v);
		return ofs[1] ? {v, 16'h0000} : {16'h0000, v};
	endfunction

	function automatic logic [15:0] take16(logic [7:0] ofs,
		logic [31:0] w);
		return ofs[1] ? w[31:16] : w[15:0];
	endfunction

	function automatic logic lane_on(logic [7:0] ofs, logic [3:0] be,
		logic hi);
		return be[{ofs[1], hi}];
	endfunction

	logic cold_cap_sync;
	logic cold_cap;
	logic next_cold_cap;
	logic wake_enable;
	logic next_wake_enable;
	logic [1:0] next_power_state;
	logic next_func_reset;
	logic [31:0] next_rdata;
	logic next_ack;
	logic wake_status;
	logic csr_hit;
	logic csr_wr_lo;
	logic csr_wr_hi;
	logic [15:0] csr_wdata;
	logic wake_clear;
	logic [15:0] cap_word;
	logic [15:0] csr_word;
	logic [31:0] rd_word;

	// strap crosses in through two flops, then a third flop (cold_cap) updates bit 15
	ppmr_sync u_cold_sync (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.async_in(wake_from_cold_capable_in),
		.sync_out(cold_cap_sync)
	);

	always_comb begin
		csr_hit = cfg_wr_in && dword_hit(cfg_dw_addr_in, PPMR_OFS_CSR);
		csr_wr_lo = csr_hit && lane_on(PPMR_OFS_CSR, cfg_be_in, 1'b0);
		csr_wr_hi = csr_hit && lane_on(PPMR_OFS_CSR, cfg_be_in, 1'b1);
		csr_wdata = take16(PPMR_OFS_CSR, cfg_wdata_in);
		wake_clear = csr_wr_hi && csr_wdata[PPMR_CSR_STS_BIT]; // RULE11
	end

	ppmr_wake u_wake (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.event_in(wake_event_in),
		.clear_in(wake_clear),
		.enable_in(next_wake_enable),
		.status_out(wake_status),
		.pin_oe_out(wake_oe_out)
	);

	// capability word is fixed apart from the cold wake bit and the aux current field that follows it
	always_comb begin
		cap_word = PPMR_CAP_RESET;
		cap_word[PPMR_CAP_COLD_BIT] = cold_cap;
		cap_word[14:11] = PPMR_WAKE_SUPPORT; // RULE1
		cap_word[10] = 1'b1; // RULE2
		cap_word[9] = 1'b1; // RULE3
		cap_word[8:6] = cold_cap ? PPMR_AUX_55MA : PPMR_AUX_SELF; // RULE4
		cap_word[5] = 1'b0; // RULE5
		cap_word[4] = 1'b0; // RULE8
		cap_word[3] = 1'b0; // RULE6
		cap_word[2:0] = PPMR_CAP_REV; // RULE7
	end

	always_comb begin
		csr_word = PPMR_CSR_RESET; // RULE12 RULE16
		csr_word[PPMR_CSR_STS_BIT] = wake_status;
		csr_word[PPMR_CSR_ENB_BIT] = wake_enable;
		csr_word[PPMR_CSR_PS_LSB +: 2] = power_state_sel_out;
	end

	// only the writable bits are taken from a write
	always_comb begin
		next_cold_cap = cold_cap_sync;
		next_wake_enable = wake_enable;
		next_power_state = power_state_sel_out;
		next_func_reset = 1'b0;
		if (csr_wr_hi) begin // RULE19
			next_wake_enable = csr_wdata[PPMR_CSR_ENB_BIT]; // RULE14
		end
		if (csr_wr_lo) begin // RULE19
			next_power_state = csr_wdata[PPMR_CSR_PS_LSB +: 2]; // RULE15
		end
		// leaving D3hot for D0 resets the function, not these registers
		if (power_state_sel_out == PPMR_PS_D3 &&
			next_power_state == PPMR_PS_D0) begin // RULE9
			next_func_reset = 1'b1;
		end
	end

	// read data; the extension register always reads zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (dword_hit(cfg_dw_addr_in, PPMR_OFS_CAP)) begin
			rd_word = rd_word | place16(PPMR_OFS_CAP, cap_word);
		end
		if (dword_hit(cfg_dw_addr_in, PPMR_OFS_CSR)) begin
			rd_word = rd_word | place16(PPMR_OFS_CSR, csr_word);
		end
		if (dword_hit(cfg_dw_addr_in, PPMR_OFS_EXT)) begin
			rd_word = rd_word | place16(PPMR_OFS_EXT, PPMR_EXT_VALUE); // RULE18
		end
		next_ack = cfg_rd_in | cfg_wr_in;
		next_rdata = cfg_rd_in ? rd_word : cfg_rdata_out;
	end

	// the function reset pulse never reaches these flops
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin // RULE17
			cold_cap <= 1'b0;
			wake_enable <= 1'b0;
			power_state_sel_out <= PPMR_PS_RESET;
			func_reset_out <= 1'b0;
			cfg_rdata_out <= 32'h0000_0000;
			cfg_ack_out <= 1'b0;
		end else begin
			cold_cap <= next_cold_cap;
			wake_enable <= next_wake_enable;
			power_state_sel_out <= next_power_state;
			func_reset_out <= next_func_reset;
			cfg_rdata_out <= next_rdata;
			cfg_ack_out <= next_ack;
		end
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_cap_read;
		cfg_rd_in && dword_hit(cfg_dw_addr_in, PPMR_OFS_CAP);
	endsequence

	sequence s_csr_read;
		cfg_rd_in && dword_hit(cfg_dw_addr_in, PPMR_OFS_CSR);
	endsequence

	a_cap_fixed_bits: assert property (s_cap_read |=> // RULE1
		cfg_rdata_out[30:25] == 6'h3F && cfg_rdata_out[21:16] == 6'h02)
		else $error("capability fixed fields wrong");
	a_aux_follows_cold: assert property (s_cap_read |=> // RULE4
		cfg_rdata_out[24:22] ==
		(cfg_rdata_out[31] ? PPMR_AUX_55MA : PPMR_AUX_SELF))
		else $error("aux current disagrees with cold wake bit");
	a_csr_reserved_zero: assert property (s_csr_read |=> // RULE16
		cfg_rdata_out[14:9] == 6'h00 && cfg_rdata_out[7:2] == 6'h00)
		else $error("control/status reserved bits not zero");
	a_ext_reads_zero: assert property (s_csr_read |=> // RULE18
		cfg_rdata_out[31:16] == 16'h0000)
		else $error("extension register not zero");
	a_pin_needs_enable: assert property (wake_oe_out |-> // RULE13
		wake_enable && wake_status)
		else $error("wake pin driven while disabled");
	a_pin_follows_flag: assert property (
		wake_status && wake_enable |-> wake_oe_out) // RULE13
		else $error("wake pin not driven while enabled");
	a_status_sets: assert property (wake_event_in |=> // RULE10
		cfg_rd_in && dword_hit(cfg_dw_addr_in, PPMR_OFS_CSR) |=>
		cfg_rdata_out[15])
		else $error("wake status not set by event");
	a_zero_write_keeps: assert property (
		csr_wr_hi && !csr_wdata[PPMR_CSR_STS_BIT] && wake_status
		|=> wake_status) // RULE11
		else $error("writing zero cleared wake status");
	a_state_write: assert property (csr_wr_lo |=> // RULE15
		power_state_sel_out == $past(csr_wdata[1:0]))
		else $error("power state write not taken");
	a_ro_write_ignored: assert property (
		cfg_wr_in && dword_hit(cfg_dw_addr_in, PPMR_OFS_CAP) &&
		!csr_hit |=> $stable(power_state_sel_out) &&
		$stable(wake_enable)) // RULE19
		else $error("read-only write changed state");
	// a write in the same cycle as the pulse may legally move the enable
	a_func_reset_keeps: assert property ((func_reset_out |->
		power_state_sel_out == PPMR_PS_D0 &&
		$past(power_state_sel_out) == PPMR_PS_D3) and
		(func_reset_out && !csr_wr_hi |=> $stable(wake_enable))) // RULE9
		else $error("internal reset disturbed control/status");
	a_ack_timing: assert property (cfg_rd_in || cfg_wr_in |=>
		cfg_ack_out)
		else $error("configuration request not answered");

	c_wake_pin: cover property (wake_event_in ##1 wake_oe_out);
	c_clear_wake: cover property (wake_status ##1 wake_clear ##1
		!wake_status);
	c_d3_to_d0: cover property (func_reset_out);
	c_event_on_clear: cover property (wake_event_in && wake_clear);
endmodule

// file: sim/ppmr_host_model.sv
// host side of the wake line: pull-up on the open-drain wire
`timescale 1ns/1ps
module ppmr_host_model (
	// drive from the device
	input wire logic wake_oe_in,
	// level the host sees, active low
	output logic wake_n_out
);
	// released line floats to the pull-up, never holds the last value
	assign wake_n_out = wake_oe_in ? 1'h0 : 1'h1;
endmodule

// file: sim/ppmr_tb.sv
// self-checking bench for the power management register set
`timescale 1ns/1ps
module pci_power_mgmt_regs_tb_top;
	import ppmr_pkg::*;
	logic core_clk_in = 1'h0;
	logic reset_in = 1'h1;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic ev = 1'h0;
	logic strap = 1'h0;
	logic [5:0] addr = 6'h00;
	logic [3:0] be = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] got;
	logic ack;
	logic oe;
	logic func_rst;
	logic wake_n;
	logic [1:0] state;
	logic [1:0] ps [4] = '{PPMR_PS_D0, PPMR_PS_D1, PPMR_PS_D2, PPMR_PS_D3};
	int bad_count = 0;
	int tests_run = 0;

	always #12.5 core_clk_in = ~core_clk_in;

	ppmr_regs dut (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.cfg_rd_in(rd),
		.cfg_wr_in(wr),
		.cfg_dw_addr_in(addr),
		.cfg_be_in(be),
		.cfg_wdata_in(wdata),
		.cfg_rdata_out(rdata),
		.cfg_ack_out(ack),
		.wake_event_in(ev),
		.wake_from_cold_capable_in(strap),
		.wake_oe_out(oe),
		.power_state_sel_out(state),
		.func_reset_out(func_rst)
	);

	ppmr_host_model host (
		.wake_oe_in(oe),
		.wake_n_out(wake_n)
	);

	task summarize;
		$display("mismatches %0d, checks %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h", $time, m, g);
		end
	endtask

	task chk_bit(input logic g, input logic e, input string m);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	// one request; answer is sampled in the cycle after the taking edge
	task access(input logic r, input logic w, input logic [5:0] a,
		input logic [3:0] b, input logic [31:0] d);
		@(posedge core_clk_in);
		rd <= r;
		wr <= w;
		addr <= a;
		be <= b;
		wdata <= d;
		@(posedge core_clk_in);
		rd <= 1'h0;
		wr <= 1'h0;
		#1;
		chk_bit(ack, 1'h1, "no answer");
		got = rdata;
	endtask

	task cfg_rd(input logic [5:0] a, input logic [31:0] e, input string m);
		access(1'h1, 1'h0, a, 4'h0, 32'h0);
		chk_word(got, e, m);
	endtask

	task cfg_wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
		access(1'h0, 1'h1, a, b, d);
	endtask

	task pulse_event;
		@(posedge core_clk_in);
		ev <= 1'h1;
		@(posedge core_clk_in);
		ev <= 1'h0;
		#1;
	endtask

	initial begin
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'h0;
		cfg_rd(6'h11, {PPMR_CAP_RESET, 16'h0}, "cap reset");
		cfg_rd(6'h12, 32'h0, "csr reset");
		cfg_rd(6'h00, 32'h0, "unmapped read");
		cfg_wr(6'h11, 4'hF, 32'hFFFF_FFFF);
		cfg_rd(6'h11, {PPMR_CAP_RESET, 16'h0}, "cap written");
		cfg_wr(6'h12, 4'hF, 32'hFFFF_FFFF);
		cfg_rd(6'h12, 32'h0000_0103, "csr mask");
		// leaving D3 for D0 fires the internal reset for one cycle
		cfg_wr(6'h12, 4'h1, 32'h0);
		chk_bit(func_rst, 1'h1, "no function reset");
		@(posedge core_clk_in);
		#1;
		chk_bit(func_rst, 1'h0, "function reset too long");
		cfg_rd(6'h12, 32'h0000_0100, "enable lost");
		for (int i = 0; i < 4; i++) begin
			cfg_wr(6'h12, 4'h1, {30'h0, ps[i]});
			chk_word({30'h0, state}, {30'h0, ps[i]}, "state");
		end
		strap <= 1'h1;
		repeat (5) @(posedge core_clk_in);
		cfg_rd(6'h11, {PPMR_CAP_RESET | 16'h8040, 16'h0}, "cold cap");
		cfg_wr(6'h12, 4'h2, 32'h0);
		pulse_event();
		chk_bit(wake_n, 1'h1, "pin driven while disabled");
		cfg_rd(6'h12, 32'h0000_8003, "status not set");
		cfg_wr(6'h12, 4'h2, 32'h0);
		cfg_rd(6'h12, 32'h0000_8003, "zero write cleared");
		cfg_wr(6'h12, 4'h2, 32'h0000_8000);
		cfg_rd(6'h12, 32'h0000_0003, "status not cleared");
		cfg_wr(6'h12, 4'h2, 32'h0000_0100);
		pulse_event();
		chk_bit(wake_n, 1'h0, "pin not driven");
		cfg_wr(6'h12, 4'h2, 32'h0000_8100);
		chk_bit(wake_n, 1'h1, "pin not released");
		// global reset in mid-run clears the sticky bits
		@(posedge core_clk_in);
		reset_in <= 1'h1;
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'h0;
		cfg_rd(6'h12, 32'h0, "csr after reset");
		chk_word({30'h0, state}, 32'h0, "state after reset");
		summarize();
	end

	// whole run is near 60 cycles; this only catches a hang
	initial begin
		repeat (5000) @(posedge core_clk_in);
		bad_count++;
		summarize();
	end
endmodule
